// file: core/frame_buffer_glue_logic.sv
// Glue logic between a CRT controller's multiplexed bus and a four-bank DRAM.
// Assumes controller pins and DRAM read data are asynchronous to clk.
//
// Functional notes
// R1 - Controller shows the 20-bit attribute word in the last cycle before line sync.
// R2 - Under horizontal zoom only the first display cycle of a group is real.
// R3 - Unused top raster bit is driven as 0 during character data phases.
// R4 - Character address phases carry the raster pointer bits 4 to 7 on upper lines.
// R5 - A draw address is 20 bits; glue captures it and applies it to memory.
// R6 - Draw address phase keeps clock, phase, strobe, draw and character low.
// R7 - A draw address phase is followed by a read or a write data phase.
// R8 - The no-draw dummy pair leaves memory unchanged.
// R9 - Low 16 address bits are captured while the address strobe is active.
// R10 - Latched address splits into 8-bit row and column by a row/column select.
// R11 - Two low address bits decode one bank write enable, only on writes.
// R12 - In dual access mode 1 write only when read flag and draw are low.
// R13 - Drawing reads pick one 16-bit word of 64 by the two low address bits.
// R14 - Read mux enabled for draw, read and graphics, timed by column strobe.
// R15 - Display reads load 64 bits into eight 8-bit shifters, shifted per pixel.
// R16 - Load is asserted so the group's last pixel edge reloads the shifters.
// R17 - Memory cycles every two controller clocks; pixel clock is twice controller.
// R18 - Each display cycle reads four 16-bit words from four banks.
// R19 - Each pixel carries two bits each of red, green, blue and intensity.
// R20 - Shift load is inhibited during drawing and dummy cycles.
// R21 - Dummy cycles are told apart by a strobe-set, cycle-end-cleared flag.
// R22 - Attribute latch captures at every cycle end while line sync is low.
// R23 - The bank write enable is asserted before the column strobe falls.
// R24 - Read word drives the controller only in drawing read data phases.
`timescale 1ns/1ps

module frame_buffer_glue_logic
	import fb_glue_pkg::*;
#(
	parameter int unsigned PIX_DIV       = PIX_DIV_DEF,
	parameter bit          HAS_CHAR_MEM  = 1'b1
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [LOW_ADDR_W-1:0]  muxed_addr_data_lines,
	input  wire logic [UP_ADDR_W-1:0]   upper_addr_lines,
	input  wire ctrl_status_t           ctrl_status,
	input  wire logic                   dual_access_mode1,
	input  wire logic [READ_W-1:0]      dram_rdata,
	output logic                        controller_clock,
	output logic [LOW_ADDR_W-1:0]       muxed_addr_data_out,
	output logic                        muxed_addr_data_oe,
	output dram_ctl_t                   dram_ctl,
	output logic [BANKS-1:0]            bank_we_n,
	output logic [WORD_W-1:0]           dram_wdata,
	output logic                        dram_wdata_oe,
	output logic [UP_ADDR_W-1:0]        upper_addr_q,
	output logic [ATTR_W-1:0]           attr_word,
	output pixel_t                      pixel_out
);

	localparam int unsigned DIV_W = $clog2(PIX_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PIX_DIV - 1);

	// Two-stage synchronisers for every pin from the controller and the DRAM.
	logic [LOW_ADDR_W-1:0] mad_s1_reg, mad_reg;
	logic [UP_ADDR_W-1:0]  up_s1_reg, up_reg;
	ctrl_status_t          st_s1_reg, st_reg;
	logic                  dam_s1_reg, dam_reg;
	logic [READ_W-1:0]     rd_s1_reg, rd_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			mad_s1_reg <= '0;
			mad_reg    <= '0;
			up_s1_reg  <= '0;
			up_reg     <= '0;
			st_s1_reg  <= '1;
			st_reg     <= '1;
			dam_s1_reg <= 1'b0;
			dam_reg    <= 1'b0;
			rd_s1_reg  <= '0;
			rd_reg     <= '0;
		end else begin
			mad_s1_reg <= muxed_addr_data_lines;
			mad_reg    <= mad_s1_reg;
			up_s1_reg  <= upper_addr_lines;
			up_reg     <= up_s1_reg;
			st_s1_reg  <= ctrl_status;
			st_reg     <= st_s1_reg;
			dam_s1_reg <= dual_access_mode1;
			dam_reg    <= dam_s1_reg;
			rd_s1_reg  <= dram_rdata;
			rd_reg     <= rd_s1_reg;
		end
	end

	// Pixel-rate enable from a divider on clk.
	logic [DIV_W-1:0] div_reg;
	logic             pix_en;

	always_ff @(posedge clk) begin
		if (rst) begin
			div_reg <= '0;
		end else if (div_reg == DIV_LAST) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + DIV_W'(1);
		end
	end

	assign pix_en = (div_reg == DIV_LAST);

	// Memory cycle phase: four pixel ticks, two controller clocks per cycle.
	logic [1:0] phase_reg;
	logic       cycle_end;

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_reg <= PH_ADDR0;
		end else if (pix_en) begin
			phase_reg <= phase_reg + 2'h1; // see R17
		end
	end

	assign cycle_end = pix_en && (phase_reg == PH_DATA1);

	// Controller clock toggles once per pixel tick, so it runs at half pixel rate.
	always_ff @(posedge clk) begin
		if (rst) begin
			controller_clock <= 1'b0;
		end else if (pix_en) begin
			controller_clock <= ~phase_reg[0]; // see R17
		end
	end

	// Address latch: follows the bus while the strobe is low, holds otherwise.
	logic [LOW_ADDR_W-1:0] addr_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_reg     <= ADDR_RST;
			upper_addr_q <= '0;
		end else if (!st_reg.addr_strobe_n) begin
			addr_reg     <= mad_reg; // see R9
			upper_addr_q <= up_reg; // see R5
		end
	end

	// Valid flag: set by the strobe, cleared at cycle end; strobe wins a tie.
	logic valid_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			valid_reg <= 1'b0;
		end else if (!st_reg.addr_strobe_n) begin
			valid_reg <= 1'b1; // see R21
		end else if (cycle_end) begin
			valid_reg <= 1'b0; // see R21
		end
	end

	// Phase-derived strobes and address mux toward the DRAM array.
	logic in_data_phase;
	logic cas_phase;

	assign in_data_phase = phase_reg[1];
	assign cas_phase     = (phase_reg == PH_DATA1);

	always_ff @(posedge clk) begin
		if (rst) begin
			dram_ctl.ras_n   <= 1'b1;
			dram_ctl.cas_n   <= 1'b1;
			dram_ctl.row_col <= 1'b1;
			dram_ctl.addr    <= '0;
		end else begin
			dram_ctl.ras_n   <= !(valid_reg && (phase_reg != PH_ADDR0));
			dram_ctl.cas_n   <= !(valid_reg && cas_phase); // see R23
			dram_ctl.row_col <= !in_data_phase; // see R10
			if (!in_data_phase) begin
				dram_ctl.addr <= addr_reg[ROW_LSB +: DRAM_ADDR_W]; // see R10
			end else begin
				dram_ctl.addr <= addr_reg[COL_LSB +: DRAM_ADDR_W]; // see R10
			end
		end
	end

	// Write qualification; dummy pairs carry a high read flag and never write.
	logic                  write_ok;
	logic [BANK_SEL_W-1:0] bank_sel;

	assign bank_sel = addr_reg[BANK_LSB +: BANK_SEL_W];
	assign write_ok = dam_reg ? (!st_reg.mem_read_flag && !st_reg.draw_n) // see R12
	                          : !st_reg.mem_read_flag; // see R11 R8

	// Per-bank write enable decode, asserted from the first data tick on.
	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank_we
			always_ff @(posedge clk) begin
				if (rst) begin
					bank_we_n[b] <= WE_N_RST[b];
				end else begin
					bank_we_n[b] <= !(valid_reg && in_data_phase && write_ok
					                  && (bank_sel == BANK_SEL_W'(b))); // see R11 R23
				end
			end
		end
	endgenerate

	// Write data is driven to all banks only while a write is under way.
	always_ff @(posedge clk) begin
		if (rst) begin
			dram_wdata    <= '0;
			dram_wdata_oe <= 1'b0;
		end else begin
			dram_wdata    <= mad_reg;
			dram_wdata_oe <= valid_reg && in_data_phase && write_ok; // see R5
		end
	end

	// Read mux enable: draw, read, graphics, gated by the column strobe phase.
	logic rd_en;

	assign rd_en = valid_reg && cas_phase && !st_reg.draw_n && st_reg.mem_read_flag
	               && !(HAS_CHAR_MEM && st_reg.char_access_flag); // see R14

	// 64:16 word select; the path is released outside drawing reads.
	always_ff @(posedge clk) begin
		if (rst) begin
			muxed_addr_data_out <= '0;
			muxed_addr_data_oe  <= 1'b0;
		end else begin
			muxed_addr_data_out <= rd_reg[bank_sel*WORD_W +: WORD_W]; // see R13 R18
			muxed_addr_data_oe  <= rd_en; // see R24 R14
		end
	end

	// Attribute latch: every cycle end while line sync is low; last one stays.
	always_ff @(posedge clk) begin
		if (rst) begin
			attr_word <= ATTR_RST;
		end else if (cycle_end && !st_reg.hsync_n) begin
			attr_word <= {up_reg, mad_reg}; // see R22
		end
	end

	// Shift load for every strobed non-draw cycle, read or write, on the group's last pixel edge.
	logic load_now;

	assign load_now = cycle_end && valid_reg && st_reg.draw_n; // see R20 R16

	logic [PLANES-1:0] pix_bits;

	pixel_serializer #(
		.N_PLANES (PLANES),
		.DEPTH    (SHIFT_DEPTH)
	) u_serializer (
		.clk      (clk),
		.rst      (rst),
		.pix_en   (pix_en),
		.load     (load_now),
		.par_in   (rd_reg),
		.pix_bits (pix_bits)
	);

	// Registered pixel, two bits per colour component.
	always_ff @(posedge clk) begin
		if (rst) begin
			pixel_out <= '0;
		end else if (pix_en) begin
			pixel_out <= pixel_t'(pix_bits); // see R19
		end
	end

endmodule : frame_buffer_glue_logic

// file: core/pixel_serializer.sv
// Parallel-load shift registers that turn a 64-bit display read into pixels.
// Assumes load and pix_en are one-cycle enables on clk from the caller.
`timescale 1ns/1ps

module pixel_serializer
	import fb_glue_pkg::*;
#(
	parameter int unsigned N_PLANES = PLANES,
	parameter int unsigned DEPTH    = SHIFT_DEPTH
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      pix_en,
	input  wire logic                      load,
	input  wire logic [N_PLANES*DEPTH-1:0] par_in,
	output logic      [N_PLANES-1:0]       pix_bits
);

	// One shift register per bit plane; load wins over shift on a pixel tick.
	genvar p;
	generate
		for (p = 0; p < N_PLANES; p++) begin : g_plane
			logic [DEPTH-1:0] shreg_reg;
			always_ff @(posedge clk) begin
				if (rst) begin
					shreg_reg <= '0;
				end else if (pix_en && load) begin
					shreg_reg <= par_in[p*DEPTH +: DEPTH]; // see R15
				end else if (pix_en) begin
					shreg_reg <= {shreg_reg[DEPTH-2:0], 1'b0}; // see R15
				end
			end
			assign pix_bits[p] = shreg_reg[DEPTH-1];
		end
	endgenerate

endmodule : pixel_serializer

// file: dv/dram_bank_model.sv
// Behavioural four-bank DRAM array that sits behind the glue logic.
// Assumes strobes are low active and the array is preset to a known pattern.
`timescale 1ns/1ps

module dram_bank_model
	import fb_glue_pkg::*;
(
	input  wire logic              clk,
	input  wire dram_ctl_t         dram_ctl,
	input  wire logic [BANKS-1:0]  bank_we_n,
	input  wire logic [WORD_W-1:0] dram_wdata,
	output logic      [READ_W-1:0] dram_rdata
);
	logic [WORD_W-1:0] mem [BANKS][65536];
	logic [7:0]        row_q;
	logic [15:0]       loc;
	logic              ras_d;
	logic              cas_d;

	// Presets every bank so read data are known to the bench.
	initial begin
		foreach (mem[b, a]) mem[b][a] = WORD_W'(16'h1111 * (b + 1));
		dram_rdata = '0;
		ras_d = 1'b1;
		cas_d = 1'b1;
		row_q = 8'h00;
		loc = 16'h0000;
	end

	// Row at the row strobe, column and write at the column strobe, all banks read.
	always @(posedge clk) begin
		ras_d <= dram_ctl.ras_n;
		cas_d <= dram_ctl.cas_n;
		if (ras_d && !dram_ctl.ras_n) row_q <= dram_ctl.addr;
		if (cas_d && !dram_ctl.cas_n) begin
			loc = {row_q, dram_ctl.addr};
			for (int b = 0; b < BANKS; b++) if (!bank_we_n[b]) mem[b][loc] <= dram_wdata;
		end
		if (!dram_ctl.cas_n && !dram_ctl.ras_n) begin
			for (int b = 0; b < BANKS; b++) dram_rdata[16*b +: 16] <= mem[b][loc];
		end else begin
			dram_rdata <= ~dram_rdata; // Released outputs do not hold the last value.
		end
	end

endmodule : dram_bank_model

// file: dv/fb_glue_checker_sva.sv
// Checker for the DRAM strobes, write enables and read path of the glue logic.
// Assumes it is bound into the glue logic top and sees only its ports.
`timescale 1ns/1ps

module fb_glue_checker
	import fb_glue_pkg::*;
#(
	parameter int unsigned PIX_DIV = PIX_DIV_DEF
) (
	input wire logic             clk,
	input wire logic             rst,
	input wire logic             controller_clock,
	input wire logic             muxed_addr_data_oe,
	input wire dram_ctl_t        dram_ctl,
	input wire logic [BANKS-1:0] bank_we_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [7:0] tick_cnt;
	logic       seen;
	logic       cc_d;

	// Counts clocks between controller clock edges once the first edge is seen.
	always_ff @(posedge clk) begin
		cc_d <= controller_clock;
		if (rst) begin
			tick_cnt <= 8'h00;
			seen     <= 1'b0;
		end else if (controller_clock != cc_d) begin
			tick_cnt <= 8'h01;
			seen     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 8'h01;
		end
	end

	a_cc_half_period: assert property (seen && controller_clock != cc_d |-> tick_cnt == 8'(PIX_DIV))
		else $error("Controller clock half period is wrong.");
	a_we_one_bank: assert property (bank_we_n != 4'hF |-> $onehot(~bank_we_n))
		else $error("More than one bank is write enabled.");
	a_we_col_bank: assert property (bank_we_n != 4'hF && !dram_ctl.row_col |-> !bank_we_n[dram_ctl.addr[1:0]])
		else $error("Write enable does not match the low address bits.");
	a_we_needs_ras: assert property (bank_we_n != 4'hF |-> !dram_ctl.ras_n)
		else $error("Write enable outside an addressed cycle.");
	a_we_before_cas: assert property ($fell(dram_ctl.cas_n) |-> bank_we_n == $past(bank_we_n))
		else $error("Write enable changed as the column strobe fell.");
	a_cas_on_col: assert property ($fell(dram_ctl.cas_n) |-> !dram_ctl.ras_n && !dram_ctl.row_col)
		else $error("Column strobe fell without row strobe or column address.");
	a_oe_with_cas: assert property (muxed_addr_data_oe |-> !dram_ctl.cas_n && bank_we_n == 4'hF)
		else $error("Read word driven outside a read column phase.");
	a_release_all: assert property ($rose(dram_ctl.cas_n) |-> $rose(dram_ctl.ras_n) && !muxed_addr_data_oe)
		else $error("Strobes did not release together at cycle end.");
	a_ras_hold_low: assert property ($fell(dram_ctl.ras_n) |=> (!dram_ctl.ras_n) [*8])
		else $error("Row strobe too short.");

endmodule : fb_glue_checker

bind frame_buffer_glue_logic fb_glue_checker #(.PIX_DIV(PIX_DIV)) fb_glue_checker_inst (
	.clk(clk), .rst(rst), .controller_clock(controller_clock),
	.muxed_addr_data_oe(muxed_addr_data_oe), .dram_ctl(dram_ctl), .bank_we_n(bank_we_n));

// file: dv/frame_buffer_glue_logic_test.sv
// Self-checking bench: drives controller cycles and judges the glue outputs.
// Assumes the DRAM model and checker are compiled before it.
`timescale 1ns/1ps

module frame_buffer_glue_logic_test import fb_glue_pkg::*;;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic [15:0]  lines = 16'h0000;
	logic [3:0]   up = 4'h0;
	ctrl_status_t st = 6'h2D;
	logic         dual = 1'b0;
	logic [63:0]  rdata;
	logic         cc, cc_d, moe, woe, ras_s, oe_s, woe_s;
	logic [15:0]  mout, wdata, word_s;
	logic [7:0]   row_s, col_s;
	logic [3:0]   we_n, upq, we_s;
	logic [19:0]  attr;
	logic [1:0]   ph;
	dram_ctl_t    dctl;
	pixel_t       pix;
	int           n_mismatch = 0;
	int           check_count = 0;

	frame_buffer_glue_logic frame_buffer_glue_logic_inst (.clk(clk), .rst(rst),
		.muxed_addr_data_lines(lines), .upper_addr_lines(up), .ctrl_status(st),
		.dual_access_mode1(dual), .dram_rdata(rdata), .controller_clock(cc),
		.muxed_addr_data_out(mout), .muxed_addr_data_oe(moe), .dram_ctl(dctl),
		.bank_we_n(we_n), .dram_wdata(wdata), .dram_wdata_oe(woe),
		.upper_addr_q(upq), .attr_word(attr), .pixel_out(pix));
	dram_bank_model dram_bank_model_inst (.clk(clk), .dram_ctl(dctl), .bank_we_n(we_n),
		.dram_wdata(wdata), .dram_rdata(rdata));

	// Clock at 125 MHz.
	always #4 clk = ~clk;

	// Tracks the memory cycle phase from the controller clock edges.
	always @(posedge clk) begin
		cc_d <= cc;
		if (rst) ph <= 2'h0;
		else if (cc !== cc_d) ph <= ph + 2'h1;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_ph(input logic [1:0] p, input int k);
		do @(posedge clk); while (ph !== p);
		repeat (k) @(posedge clk);
	endtask : wait_ph

	function automatic logic [7:0] pix_of(input logic [63:0] d, input int k);
		logic [7:0] r;
		for (int p = 0; p < 8; p++) r[p] = d[8*p + k];
		return r;
	endfunction : pix_of

	// One controller cycle: address phase, then data phase, with output snapshots.
	task automatic mem_cycle(input logic [5:0] s, input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] u);
		wait_ph(2'h3, 0);
		wait_ph(2'h0, 0);
		st <= s;
		lines <= a;
		up <= u;
		wait_ph(2'h1, 3);
		row_s = dctl.addr;
		ras_s = dctl.ras_n;
		wait_ph(2'h2, 0);
		st.addr_strobe_n <= 1'b1;
		lines <= d;
		wait_ph(2'h3, 4);
		col_s = dctl.addr;
		we_s = we_n;
		oe_s = moe;
		woe_s = woe;
		word_s = mout;
	endtask : mem_cycle

	task automatic t_draw;
		logic [15:0] a;
		for (int b = 0; b < 4; b++) begin
			a = 16'h1230 | 16'(b);
			mem_cycle(6'h01, a, 16'hBE00 | 16'(b), 4'h5);
			check("row", 32'(row_s), 32'(a[15:8]));
			check("col", 32'(col_s), 32'(a[7:0]));
			check("we", 32'(we_s), 32'(4'(~(4'h1 << b))));
			check("woe", 32'(woe_s), 32'h1);
			check("wdata", 32'(wdata), 32'(16'hBE00 | 16'(b)));
			check("upper", 32'(upq), 32'h5);
			mem_cycle(6'h09, a, ~a, 4'h5);
			check("oe", 32'(oe_s), 32'h1);
			check("word", 32'(word_s), 32'(16'hBE00 | 16'(b)));
			check("we_rd", 32'(we_s), 32'hF);
			check("woe_rd", 32'(woe_s), 32'h0);
		end
		// Character cycle keeps the top upper line low, as an unused raster bit.
		mem_cycle(6'h0B, a, ~a, 4'h5);
		check("oe_chr", 32'(oe_s), 32'h0);
		$display("t_draw done");
	endtask : t_draw

	task automatic t_mode1;
		dual <= 1'b1;
		mem_cycle(6'h05, 16'h4442, 16'h7777, 4'h0);
		check("we_m1", 32'(we_s), 32'hF);
		dual <= 1'b0;
		mem_cycle(6'h05, 16'h4442, 16'h7777, 4'h0);
		check("we_m0", 32'(we_s), 32'hB);
		$display("t_mode1 done");
	endtask : t_mode1

	task automatic t_dummy;
		mem_cycle(6'h2D, 16'h0000, 16'h5A5A, 4'h0);
		check("ras", 32'(ras_s), 32'h1);
		check("we_dm", 32'(we_s), 32'hF);
		check("oe_dm", 32'(oe_s), 32'h0);
		$display("t_dummy done");
	endtask : t_dummy

	task automatic t_display;
		logic [63:0] exp;
		int          i;
		exp = {16'h4444, 16'h3333, 16'hBE01, 16'h1111};
		mem_cycle(6'h0D, 16'h1231, ~16'h1231, 4'h5);
		i = 0;
		while (pix !== pix_of(exp, 7) && i < 20) begin
			@(posedge clk);
			i++;
		end
		check("pix7", 32'(pix), 32'(pix_of(exp, 7)));
		repeat (5 * PIX_DIV_DEF) @(posedge clk);
		check("pix2", 32'(pix), 32'(pix_of(exp, 2)));
		$display("t_display done");
	endtask : t_display

	task automatic t_attr;
		mem_cycle(6'h2C, 16'hA123, 16'hA123, 4'h9);
		repeat (3) @(posedge clk);
		check("attr", 32'(attr), 32'h9A123);
		mem_cycle(6'h2D, 16'h0F0F, 16'h0F0F, 4'h3);
		repeat (3) @(posedge clk);
		check("attr_hold", 32'(attr), 32'h9A123);
		$display("t_attr done");
	endtask : t_attr

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run

	// Main sequence after a ten-cycle reset.
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_draw();
		t_mode1();
		t_dummy();
		t_display();
		t_attr();
		complete_run();
	end

	// Watchdog well beyond the roughly five hundred cycles the tests take.
	initial begin
		#(8 * 20000);
		n_mismatch++;
		complete_run();
	end

endmodule : frame_buffer_glue_logic_test

// file: include/fb_glue_pkg.sv
// Shared constants and carrier types for the frame-buffer glue logic.
// Assumes one system clock; all slower rates are enables derived from it.
package fb_glue_pkg;

	// Pixel ticks per memory cycle (two controller clocks, two pixels each).
	localparam int unsigned PHASES_PER_CYCLE = 4;
	localparam logic [1:0]  PH_ADDR0         = 2'h0;
	localparam logic [1:0]  PH_ADDR1         = 2'h1;
	localparam logic [1:0]  PH_DATA0         = 2'h2;
	localparam logic [1:0]  PH_DATA1         = 2'h3;

	// Address and data widths of the controller bus and the DRAM array.
	localparam int unsigned LOW_ADDR_W   = 16;
	localparam int unsigned UP_ADDR_W    = 4;
	localparam int unsigned ATTR_W       = 20;
	localparam int unsigned DRAM_ADDR_W  = 8;
	localparam int unsigned WORD_W       = 16;
	localparam int unsigned BANKS        = 4;
	localparam int unsigned BANK_SEL_W   = 2;
	localparam int unsigned READ_W       = 64;

	// Field positions inside the latched low address.
	localparam int unsigned ROW_LSB      = 8;
	localparam int unsigned COL_LSB      = 0;
	localparam int unsigned BANK_LSB     = 0;

	// Pixel planes and serializer depth.
	localparam int unsigned PLANES       = 8;
	localparam int unsigned SHIFT_DEPTH  = 8;

	// Default clock divider from clk to the pixel rate.
	localparam int unsigned PIX_DIV_DEF  = 6;

	// Reset values.
	localparam logic [LOW_ADDR_W-1:0] ADDR_RST  = 16'h0000;
	localparam logic [ATTR_W-1:0]     ATTR_RST  = 20'h00000;
	localparam logic [BANKS-1:0]      WE_N_RST  = 4'hF;

	// Status pins of the controller, grouped as they arrive.
	typedef struct packed {
		logic addr_strobe_n;
		logic mem_cycle_phase;
		logic mem_read_flag;
		logic draw_n;
		logic char_access_flag;
		logic hsync_n;
	} ctrl_status_t;

	// One pixel: two bits each of intensity, blue, green and red.
	typedef struct packed {
		logic [1:0] intensity;
		logic [1:0] blue;
		logic [1:0] green;
		logic [1:0] red;
	} pixel_t;

	// DRAM strobes and address toward the array.
	typedef struct packed {
		logic                   ras_n;
		logic                   cas_n;
		logic                   row_col;
		logic [DRAM_ADDR_W-1:0] addr;
	} dram_ctl_t;

endpackage : fb_glue_pkg
